// ### core/dsfs_pkg.sv
/*
 * Shared constants for the serial frame link of a single-channel output
 * converter: frame lengths, register addresses and timing counts.
 * Assumes a 40 MHz system clock on both ends.
 */
package dsfs_pkg;
   // -----------------------------------------
   // frame layout
   // -----------------------------------------
   localparam int FRAME_LEN = 24;
   localparam int FRAME_LEN_CHK = 32;
   localparam logic [7:0] ADDR_CODE = 8'h01;
   localparam logic [7:0] ADDR_CONFIG = 8'h02;
   localparam int RANGE_LSB = 0;
   localparam int RANGE_W = 4;
   // -----------------------------------------
   // timing
   // -----------------------------------------
   localparam int CLK_NS = 25;
   localparam int T_GAP_REG_NS = 500;
   localparam int T_GAP_CODE_NS = 1500;
   localparam int T_GAP_RANGE_NS = 500000;
   localparam int T_RST_LOW_NS = 5000;
   localparam int T_RST_WAIT_NS = 100000;
   localparam int T_LOAD_AFTER_NS = 1500;
   localparam int T_LOAD_LEAD_NS = 750;
   localparam int T_LOAD_LOW_NS = 250;
   localparam int T_SETUP_NS = 33;
   localparam int T_SCLK_WR_NS = 33;
   localparam int T_SCLK_RD_NS = 120;

   // least time to whole cycles, never below one
   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_ceil

   localparam int GAP_REG_CYC = cyc_ceil(T_GAP_REG_NS);
   localparam int GAP_CODE_CYC = cyc_ceil(T_GAP_CODE_NS);
   localparam int GAP_RANGE_CYC = cyc_ceil(T_GAP_RANGE_NS);
   localparam int RST_LOW_CYC = cyc_ceil(T_RST_LOW_NS);
   localparam int RST_WAIT_CYC = cyc_ceil(T_RST_WAIT_NS);
   localparam int LOAD_AFTER_CYC = cyc_ceil(T_LOAD_AFTER_NS);
   localparam int LOAD_LOW_CYC = cyc_ceil(T_LOAD_LOW_NS);
   localparam int LOAD_REST_CYC = cyc_ceil(T_LOAD_LEAD_NS) - LOAD_LOW_CYC;
   localparam int SETUP_CYC = cyc_ceil(T_SETUP_NS);
   localparam int HALF_WR_CYC = cyc_ceil((T_SCLK_WR_NS + 1) / 2);
   localparam int HALF_RD_CYC = cyc_ceil(T_SCLK_RD_NS / 2);
   localparam int CNT_W = 15;
   localparam int TMR_W = 12;
endpackage : dsfs_pkg

// ### core/dsfs_link_if.sv
/*
 * Link between host and converter: select, clock, data both ways,
 * output load strobe and device reset pin.
 * Assumes the host drives every pin except the returned data.
 */
`timescale 1ns/1ps
interface dsfs_link_if;
   logic sclk;
   logic sel_n;
   logic sdi;
   logic sdo;
   logic output_load_n;
   logic dev_rst_n;

   modport dev (
      input sclk,
      input sel_n,
      input sdi,
      input output_load_n,
      input dev_rst_n,
      output sdo
   );
   modport host (
      output sclk,
      output sel_n,
      output sdi,
      output output_load_n,
      output dev_rst_n,
      input sdo
   );
endinterface : dsfs_link_if

// ### core/dsfs_dev.sv
/*
 * Converter end: shifts frames in on the link clock, hands them to the
 * system clock and keeps the input and output code registers.
 * Assumes the host keeps the select gaps and load spacing.
 */
`timescale 1ns/1ps
module dsfs_dev (
   input wire logic clk_sys,
   input wire logic rst_n,
   dsfs_link_if.dev link,
   input wire logic chk_en,
   output logic [15:0] code_out,
   output logic [3:0] range_out,
   output logic update_pulse,
   output logic frame_drop
);
   // -----------------------------------------
   // link clock domain
   // -----------------------------------------
   typedef struct packed {
      logic [5:0] cnt;
      logic [31:0] shift;
      logic [23:0] hold;
      logic tog;
      logic [31:0] rb;
      logic sdo;
      logic chk_m;
      logic chk_s;
   } dsfs_lnk_s;

   dsfs_lnk_s l_reg, l_next;
   logic armed;
   logic [31:0] w;
   logic [5:0] n;
   logic [5:0] len;

   always_ff @(negedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end

   // shift, count and readback
   always_comb begin
      l_next = l_reg;
      l_next.chk_m = chk_en;
      l_next.chk_s = l_reg.chk_m;
      w = {l_reg.shift[30:0], link.sdi};
      len = l_reg.chk_s ? 6'(dsfs_pkg::FRAME_LEN_CHK) : 6'(dsfs_pkg::FRAME_LEN);
      n = armed ? l_reg.cnt + 6'h01 : 6'h01;
      if (n == 6'h3f) begin
         n = l_reg.cnt;
      end
      l_next.cnt = n;
      l_next.shift = w;
      l_next.rb = {l_reg.rb[30:0], 1'b0};
      l_next.sdo = l_reg.rb[30];
      // frame ends at edge 24 or 32
      if (n == len) begin
         l_next.hold = l_reg.chk_s ? w[31:8] : w[23:0];
         l_next.tog = ~l_reg.tog;
         l_next.rb = l_reg.chk_s ? w : {w[23:0], 8'h00};
         l_next.sdo = l_reg.chk_s ? w[31] : w[23];
      end else if (n > len) begin
         l_next.sdo = 1'b0;
         l_next.rb = l_reg.rb;
      end
      // edges with select high move nothing but the chk_en synchroniser
      if (link.sel_n) begin
         l_next.cnt = l_reg.cnt;
         l_next.shift = l_reg.shift;
         l_next.rb = l_reg.rb;
         l_next.sdo = l_reg.sdo;
      end
   end

   always_ff @(negedge link.sclk or negedge rst_n) begin
      if (!rst_n) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   assign link.sdo = l_reg.sdo;

   // -----------------------------------------
   // system clock domain
   // -----------------------------------------
   typedef struct packed {
      logic tog_m, tog_s, tog_d;
      logic sel_m, sel_s, sel_d;
      logic ld_m, ld_s, ld_d;
      logic prst_m, prst_s;
      logic [23:0] word;
      logic ok;
      logic [15:0] in_code;
      logic [15:0] code;
      logic [3:0] range;
      logic pending;
      logic upd;
      logic drop;
   } dsfs_sys_s;

   dsfs_sys_s s_reg, s_next;
   logic [23:0] wd;
   logic ok;

   // frame decode and output update
   always_comb begin
      s_next = s_reg;
      s_next.tog_m = l_reg.tog;
      s_next.tog_s = s_reg.tog_m;
      s_next.tog_d = s_reg.tog_s;
      s_next.sel_m = link.sel_n;
      s_next.sel_s = s_reg.sel_m;
      s_next.sel_d = s_reg.sel_s;
      s_next.ld_m = link.output_load_n;
      s_next.ld_s = s_reg.ld_m;
      s_next.ld_d = s_reg.ld_s;
      s_next.prst_m = link.dev_rst_n;
      s_next.prst_s = s_reg.prst_m;
      s_next.upd = 1'b0;
      s_next.drop = 1'b0;
      wd = s_reg.word;
      ok = s_reg.ok;
      // hold is stable once its toggle lands
      if (s_reg.tog_s != s_reg.tog_d) begin
         wd = l_reg.hold;
         ok = 1'b1;
      end
      s_next.word = wd;
      s_next.ok = ok;
      if (s_reg.sel_s && !s_reg.sel_d) begin
         s_next.ok = 1'b0;
         s_next.drop = ~ok;
         if (ok && wd[23:16] == dsfs_pkg::ADDR_CODE) begin
            s_next.in_code = wd[15:0];
            if (!s_reg.ld_s) begin
               s_next.code = wd[15:0];
               s_next.upd = 1'b1;
               s_next.pending = 1'b0;
            end else begin
               s_next.pending = 1'b1;
            end
         end else if (ok && wd[23:16] == dsfs_pkg::ADDR_CONFIG) begin
            s_next.range = wd[dsfs_pkg::RANGE_LSB +: dsfs_pkg::RANGE_W];
         end
      end
      // load fall moves input to output
      if (!s_reg.ld_s && s_reg.ld_d && s_reg.pending) begin
         s_next.code = s_reg.in_code;
         s_next.upd = 1'b1;
         s_next.pending = 1'b0;
      end
      // pin reset clears the converter state
      if (!s_reg.prst_s) begin
         s_next.in_code = '0;
         s_next.code = '0;
         s_next.range = '0;
         s_next.pending = 1'b0;
         s_next.ok = 1'b0;
         s_next.upd = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         // synchronisers start at the idle-high pin level, no false edge
         s_reg.sel_m <= 1'b1;
         s_reg.sel_s <= 1'b1;
         s_reg.sel_d <= 1'b1;
         s_reg.ld_m <= 1'b1;
         s_reg.ld_s <= 1'b1;
         s_reg.ld_d <= 1'b1;
         s_reg.prst_m <= 1'b1;
         s_reg.prst_s <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign code_out = s_reg.code;
   assign range_out = s_reg.range;
   assign update_pulse = s_reg.upd;
   assign frame_drop = s_reg.drop;
endmodule : dsfs_dev

// ### core/dsfs_host.sv
/*
 * Host end: makes the link clock by a divider, sends frames, reads the
 * returned data and paces select gaps, load pulses and device reset.
 * Assumes the user side runs on the same system clock.
 */
`timescale 1ns/1ps
module dsfs_host #(
   parameter int RANGE_GAP_CYC = dsfs_pkg::GAP_RANGE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   dsfs_link_if.host link,
   input wire logic start,
   input wire logic [31:0] tx_word,
   input wire logic chk_en,
   input wire logic read_mode,
   input wire logic load_req,
   input wire logic reset_req,
   output logic busy,
   output logic [31:0] rx_word,
   output logic rx_valid
);
   // -----------------------------------------
   // state
   // -----------------------------------------
   typedef enum logic [2:0] {
      DSFS_IDLE,
      DSFS_SETUP,
      DSFS_LOW,
      DSFS_HIGH,
      DSFS_END,
      DSFS_LD_LOW,
      DSFS_LD_REST,
      DSFS_RST_LOW
   } dsfs_st_e;

   typedef struct packed {
      dsfs_st_e st;
      logic rst_wait;
      logic [dsfs_pkg::TMR_W-1:0] tmr;
      logic [dsfs_pkg::TMR_W-1:0] half;
      logic [5:0] bits;
      logic [5:0] len;
      logic rd;
      logic [31:0] tx;
      logic [31:0] rx;
      logic [dsfs_pkg::CNT_W-1:0] gap;
      logic [dsfs_pkg::CNT_W-1:0] need;
      logic [3:0] last_range;
      logic ld_want;
      logic rst_want;
      logic sclk;
      logic sel_n;
      logic sdi;
      logic load_n;
      logic dev_rst_n;
      logic sdo_m;
      logic sdo_s;
      logic busy;
      logic [31:0] rx_word;
      logic rx_valid;
   } dsfs_host_s;

   // gap counter saturates above every gap and the load wait
   localparam logic [dsfs_pkg::CNT_W-1:0] GAP_MAX = '1;

   dsfs_host_s r_reg, r_next;

   // select-high gap the finished frame asks for
   function automatic logic [dsfs_pkg::CNT_W-1:0] gap_of(
      input logic [31:0] word,
      input logic chk,
      input logic [3:0] old_range
   );
      logic [23:0] p;
      p = chk ? word[31:8] : word[23:0];
      if (p[23:16] == dsfs_pkg::ADDR_CODE) begin
         return dsfs_pkg::CNT_W'(dsfs_pkg::GAP_CODE_CYC);
      end
      if (p[23:16] == dsfs_pkg::ADDR_CONFIG &&
          p[dsfs_pkg::RANGE_LSB +: dsfs_pkg::RANGE_W] != old_range) begin
         return dsfs_pkg::CNT_W'(RANGE_GAP_CYC);
      end
      return dsfs_pkg::CNT_W'(dsfs_pkg::GAP_REG_CYC);
   endfunction : gap_of

   // -----------------------------------------
   // sequencing
   // -----------------------------------------
   logic gap_done;
   logic [23:0] pay;

   always_comb begin
      r_next = r_reg;
      r_next.sdo_m = link.sdo;
      r_next.sdo_s = r_reg.sdo_m;
      r_next.rx_valid = 1'b0;
      pay = 24'h000000;
      gap_done = (r_reg.gap >= r_reg.need);
      // requests held until they can be served
      if (load_req) begin
         r_next.ld_want = 1'b1;
      end
      if (reset_req) begin
         r_next.rst_want = 1'b1;
      end
      if (r_reg.gap != GAP_MAX) begin
         r_next.gap = r_reg.gap + 1'b1;
      end
      if (r_reg.tmr != '0) begin
         r_next.tmr = r_reg.tmr - 1'b1;
      end
      unique case (r_reg.st)
         DSFS_IDLE: begin
            if (r_reg.rst_wait) begin
               if (r_reg.tmr == '0) begin
                  r_next.rst_wait = 1'b0;
               end
            end else if (r_reg.rst_want) begin
               r_next.rst_want = 1'b0;
               r_next.dev_rst_n = 1'b0;
               r_next.tmr = dsfs_pkg::TMR_W'(dsfs_pkg::RST_LOW_CYC - 1);
               r_next.st = DSFS_RST_LOW;
            end else if (r_reg.ld_want && r_reg.gap >=
                         dsfs_pkg::CNT_W'(dsfs_pkg::LOAD_AFTER_CYC)) begin
               // load only well after select rise
               r_next.ld_want = 1'b0;
               r_next.load_n = 1'b0;
               r_next.tmr = dsfs_pkg::TMR_W'(dsfs_pkg::LOAD_LOW_CYC - 1);
               r_next.st = DSFS_LD_LOW;
            end else if (start && gap_done) begin
               r_next.len = chk_en ? 6'(dsfs_pkg::FRAME_LEN_CHK)
                                   : 6'(dsfs_pkg::FRAME_LEN);
               r_next.tx = chk_en ? tx_word : {tx_word[23:0], 8'h00};
               r_next.need = gap_of(tx_word, chk_en, r_reg.last_range);
               if (!read_mode) begin
                  pay = chk_en ? tx_word[31:8] : tx_word[23:0];
                  if (pay[23:16] == dsfs_pkg::ADDR_CONFIG) begin
                     r_next.last_range = pay[dsfs_pkg::RANGE_LSB +: dsfs_pkg::RANGE_W];
                  end
               end
               r_next.rd = read_mode;
               r_next.half = read_mode ? dsfs_pkg::TMR_W'(dsfs_pkg::HALF_RD_CYC - 1)
                                       : dsfs_pkg::TMR_W'(dsfs_pkg::HALF_WR_CYC - 1);
               r_next.bits = 6'h00;
               r_next.rx = 32'h00000000;
               r_next.sel_n = 1'b0;
               r_next.sdi = chk_en ? tx_word[31] : tx_word[23];
               r_next.tmr = dsfs_pkg::TMR_W'(dsfs_pkg::SETUP_CYC - 1);
               r_next.st = DSFS_SETUP;
            end
         end
         DSFS_SETUP, DSFS_HIGH: begin
            if (r_reg.tmr == '0) begin
               // falling edge: device takes the bit, we take its answer
               r_next.sclk = 1'b0;
               r_next.rx = {r_reg.rx[30:0], r_reg.sdo_s};
               r_next.bits = r_reg.bits + 6'h01;
               r_next.tmr = r_reg.half;
               r_next.st = DSFS_LOW;
            end
         end
         DSFS_LOW: begin
            if (r_reg.tmr == '0) begin
               r_next.sclk = 1'b1;
               r_next.tmr = r_reg.half;
               // stop after 24 or 32 falling edges
               if (r_reg.bits == r_reg.len) begin
                  r_next.st = DSFS_END;
               end else begin
                  r_next.tx = {r_reg.tx[30:0], 1'b0};
                  r_next.sdi = r_reg.tx[30];
                  r_next.st = DSFS_HIGH;
               end
            end
         end
         DSFS_END: begin
            r_next.sel_n = 1'b1;
            r_next.sdi = 1'b0;
            r_next.gap = '0;
            r_next.rx_word = r_reg.rx;
            r_next.rx_valid = r_reg.rd;
            r_next.tmr = '0;
            r_next.st = DSFS_IDLE;
         end
         DSFS_LD_LOW: begin
            // load low for its least width
            if (r_reg.tmr == '0) begin
               r_next.load_n = 1'b1;
               r_next.tmr = dsfs_pkg::TMR_W'(dsfs_pkg::LOAD_REST_CYC - 1);
               r_next.st = DSFS_LD_REST;
            end
         end
         DSFS_LD_REST: begin
            // no select rise too soon after load fall
            if (r_reg.tmr == '0) begin
               r_next.st = DSFS_IDLE;
            end
         end
         DSFS_RST_LOW: begin
            if (r_reg.tmr == '0) begin
               r_next.dev_rst_n = 1'b1;
               r_next.rst_wait = 1'b1;
               r_next.tmr = dsfs_pkg::TMR_W'(dsfs_pkg::RST_WAIT_CYC - 1);
               r_next.st = DSFS_IDLE;
            end
         end
      endcase
      r_next.busy = (r_next.st != DSFS_IDLE) || r_next.rst_wait ||
                    (r_next.gap < r_next.need);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.st <= DSFS_IDLE;
         r_reg.sclk <= 1'b1;
         r_reg.sel_n <= 1'b1;
         r_reg.load_n <= 1'b1;
         r_reg.dev_rst_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // -----------------------------------------
   // outputs
   // -----------------------------------------
   assign link.sclk = r_reg.sclk;
   assign link.sel_n = r_reg.sel_n;
   assign link.sdi = r_reg.sdi;
   assign link.output_load_n = r_reg.load_n;
   assign link.dev_rst_n = r_reg.dev_rst_n;
   assign busy = r_reg.busy;
   assign rx_word = r_reg.rx_word;
   assign rx_valid = r_reg.rx_valid;
endmodule : dsfs_host

// ### verification/dsfs_link_chk.sv
/*
 * Checker for the frame link between host and converter ends.
 * Assumes it watches the interface that joins both design ends.
 */
`timescale 1ns/1ps
module dsfs_link_chk #(
   parameter int RANGE_GAP = dsfs_pkg::GAP_RANGE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic output_load_n,
   input wire logic dev_rst_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic [15:0] hi_cnt, ld_cnt, rlow_cnt, rel_cnt, need;
   logic [5:0] fcnt;
   logic [31:0] sh;
   logic [3:0] rng;
   logic [7:0] addr;
   logic [15:0] data;
   // -----------------------------------------
   // helper counters
   // -----------------------------------------
   // frame fields from the last captured bits
   assign addr = (fcnt == 6'd32) ? sh[31:24] : sh[23:16];
   assign data = (fcnt == 6'd32) ? sh[23:8] : sh[15:0];
   // gap, load and reset counters saturating; the edge counter fcnt wraps and clears while select is high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= '1;
         ld_cnt <= '1;
         rlow_cnt <= '0;
         rel_cnt <= '1;
         fcnt <= '0;
         sh <= '0;
         rng <= '0;
         need <= 16'(dsfs_pkg::GAP_REG_CYC);
      end else begin
         hi_cnt <= !sel_n ? '0 : (hi_cnt == '1) ? hi_cnt : hi_cnt + 16'h0001;
         ld_cnt <= $fell(output_load_n) ? 16'h0001 : (ld_cnt == '1) ? ld_cnt : ld_cnt + 16'h0001;
         rlow_cnt <= dev_rst_n ? '0 : (rlow_cnt == '1) ? rlow_cnt : rlow_cnt + 16'h0001;
         rel_cnt <= !dev_rst_n ? '0 : (rel_cnt == '1) ? rel_cnt : rel_cnt + 16'h0001;
         if (sel_n) begin
            fcnt <= '0;
         end else if ($fell(sclk)) begin
            fcnt <= fcnt + 6'd1;
            sh <= {sh[30:0], sdi};
         end
         if ($rose(sel_n)) begin
            if (addr == dsfs_pkg::ADDR_CODE) need <= 16'(dsfs_pkg::GAP_CODE_CYC);
            else if (addr == dsfs_pkg::ADDR_CONFIG && data[3:0] != rng) need <= 16'(RANGE_GAP);
            else need <= 16'(dsfs_pkg::GAP_REG_CYC);
            if (addr == dsfs_pkg::ADDR_CONFIG) rng <= data[3:0];
         end
      end
   end
   // -----------------------------------------
   // assertions
   // -----------------------------------------
   a_frame_len: assert property ($rose(sel_n) |-> (fcnt == 6'd24 || fcnt == 6'd32))
      else $error("frame closed with a wrong edge count");
   a_sclk_idle: assert property (sel_n |-> sclk)
      else $error("link clock moved outside a frame");
   a_gap_reg: assert property ($fell(sel_n) |-> hi_cnt >= 16'(dsfs_pkg::GAP_REG_CYC))
      else $error("select gap too short");
   a_gap_code: assert property ($fell(sel_n) && need == 16'(dsfs_pkg::GAP_CODE_CYC)
      |-> hi_cnt >= need)
      else $error("gap after code write too short");
   a_gap_range: assert property ($fell(sel_n) && need == 16'(RANGE_GAP) |-> hi_cnt >= need)
      else $error("gap after range change too short");
   a_rst_low: assert property ($rose(dev_rst_n) |-> rlow_cnt >= 16'(dsfs_pkg::RST_LOW_CYC))
      else $error("device reset pulse too short");
   a_rst_wait: assert property ($fell(sclk) |-> rel_cnt >= 16'(dsfs_pkg::RST_WAIT_CYC))
      else $error("clock edge too soon after device reset");
   a_load_after: assert property ($fell(output_load_n)
      |-> hi_cnt >= 16'(dsfs_pkg::LOAD_AFTER_CYC))
      else $error("load strobe too soon after select rise");
   a_load_lead: assert property ($rose(sel_n)
      |-> ld_cnt >= 16'(dsfs_pkg::LOAD_LOW_CYC + dsfs_pkg::LOAD_REST_CYC))
      else $error("select rose too soon after load fall");
   a_load_width: assert property ($fell(output_load_n)
      |-> !output_load_n [*8] ##1 !output_load_n [*2])
      else $error("load strobe too short");
   c_frame32: cover property ($rose(sel_n) && fcnt == 6'd32);
   c_load: cover property ($fell(output_load_n));
   c_dev_rst: cover property ($rose(dev_rst_n));
   c_sdo_high: cover property ($fell(sclk) && sdo);
endmodule : dsfs_link_chk

// ### verification/tb_dac_serial_frame_sequencing.sv
/*
 * Bench: host and converter ends joined by the link, plus a second
 * converter end driven directly with faulty frames.
 * Assumes the design files and the checker are compiled first.
 */
`timescale 1ns/1ps
module tb_dac_serial_frame_sequencing;
   localparam int RGAP = 40;
   logic clk_sys, rst_n, start, chk, rd, load_req, reset_req, busy, rx_valid, upd, drop;
   logic upd2, drop2;
   logic [31:0] tx_word, rx_word, rx_cap, prev_w;
   logic [15:0] code_out, code2, pend, code_exp;
   logic [3:0] range_out, range2, exp_range;
   logic [7:0] kinds [6] = '{8'h01, 8'h02, 8'h05, 8'h02, 8'h01, 8'h05};
   int fails, tests_run, drops, drops1, min_ns;
   time last_fall;
   dsfs_link_if link();
   dsfs_link_if link2();
   dsfs_host #(.RANGE_GAP_CYC(RGAP)) i_dsfs_host (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(link.host), .start(start), .tx_word(tx_word), .chk_en(chk), .read_mode(rd),
      .load_req(load_req), .reset_req(reset_req), .busy(busy), .rx_word(rx_word),
      .rx_valid(rx_valid));
   dsfs_dev i_dsfs_dev (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.dev), .chk_en(chk),
      .code_out(code_out), .range_out(range_out), .update_pulse(upd), .frame_drop(drop));
   dsfs_dev i_dsfs_dev_flt (.clk_sys(clk_sys), .rst_n(rst_n), .link(link2.dev), .chk_en(1'b0),
      .code_out(code2), .range_out(range2), .update_pulse(upd2), .frame_drop(drop2));
   dsfs_link_chk #(.RANGE_GAP(RGAP)) i_dsfs_link_chk (.clk_sys(clk_sys), .rst_n(rst_n),
      .sclk(link.sclk), .sel_n(link.sel_n), .sdi(link.sdi), .sdo(link.sdo),
      .output_load_n(link.output_load_n), .dev_rst_n(link.dev_rst_n));
   // -----------------------------------------
   // clock, monitors, watchdog
   // -----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // capture read data and count dropped frames
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) rx_cap <= rx_word;
      if (drop2 === 1'b1) drops <= drops + 1;
      if (drop !== 1'b0) drops1 <= drops1 + 1;
   end
   // shortest link clock period inside read frames
   always @(negedge link.sclk) begin
      if (rd && !link.sel_n && $time - last_fall < min_ns) min_ns = $time - last_fall;
      last_fall = $time;
   end
   // cut a hung run short
   initial begin
      #1500000;
      fails++;
      print_verdict();
   end
   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (2) @(negedge clk_sys);
      while (busy !== 1'b0 && n < 6000) begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(n < 6000), 32'd1);
   endtask : wait_idle
   // one host frame, then model update and compare
   task automatic send(input logic [7:0] a, input logic [15:0] d, input logic c, input logic r);
      logic [31:0] w;
      w = c ? {a, d, 8'($urandom)} : {8'h00, a, d};
      @(negedge clk_sys);
      chk = c;
      rd = r;
      tx_word = w;
      repeat (4) @(negedge clk_sys);
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      wait_idle();
      if (a == dsfs_pkg::ADDR_CONFIG) exp_range = d[3:0];
      if (a == dsfs_pkg::ADDR_CODE) pend = d;
      prev_w = w;
      check(32'(range_out), 32'(exp_range));
      check(32'(code_out), 32'(code_exp));
   endtask : send
   // load strobe through the host, timing the update
   task automatic do_load(input bit up);
      int n;
      @(negedge clk_sys);
      load_req = 1'b1;
      @(negedge clk_sys);
      load_req = 1'b0;
      n = 0;
      while (link.output_load_n !== 1'b0 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      n = 0;
      while (upd !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      if (up) code_exp = pend;
      check(32'(up ? n <= 24 : n == 40), 32'd1);
      wait_idle();
      check(32'(code_out), 32'(code_exp));
   endtask : do_load
   // direct frame on the second link, n falling edges
   task automatic drv2(input logic [23:0] w, input int n);
      link2.sel_n = 1'b0;
      #80;
      for (int k = 0; k < n; k++) begin
         link2.sdi = (k < 24) ? w[23 - k] : 1'b0;
         #40;
         link2.sclk = 1'b0;
         #60;
         if (k >= 24) check(32'(link2.sdo), 32'd0);
         #20;
         link2.sclk = 1'b1;
         #40;
      end
      link2.sel_n = 1'b1;
   endtask : drv2
   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      logic [15:0] d;
      logic [31:0] rx_exp;
      int n;
      void'($urandom(32'h171a));
      {rst_n, start, chk, rd, load_req, reset_req} = '0;
      {tx_word, fails, tests_run, drops, drops1, last_fall} = '0;
      {exp_range, pend, code_exp} = '0;
      min_ns = 1000;
      {link2.sclk, link2.sel_n, link2.sdi, link2.output_load_n, link2.dev_rst_n} = 5'h1b;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      send(dsfs_pkg::ADDR_CODE, 16'h1234, 1'b0, 1'b0);
      @(negedge clk_sys);
      reset_req = 1'b1;
      @(negedge clk_sys);
      reset_req = 1'b0;
      wait_idle();
      do_load(1'b0);
      $display("test device reset done");
      for (int i = 0; i < 6; i++) begin
         send(kinds[i], 16'($urandom), 1'(i % 2), 1'b0);
         if (i == 2 || i == 5) do_load(1'b1);
      end
      $display("test frame kinds done");
      send(8'h05, 16'($urandom), 1'b0, 1'b0);
      rx_exp = prev_w;
      send(8'h05, 16'($urandom), 1'b0, 1'b1);
      check(32'(rx_cap[23:0]), 32'(rx_exp[23:0]));
      check(32'(min_ns >= 120), 32'd1);
      $display("test readback done");
      repeat (4) begin
         link2.sclk = 1'b0;
         #80;
         link2.sclk = 1'b1;
         #80;
      end
      link2.output_load_n = 1'b0;
      #300;
      d = 16'($urandom);
      drv2({dsfs_pkg::ADDR_CODE, d}, 24);
      n = 0;
      while (upd2 !== 1'b1 && n < 80) begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(n <= 60), 32'd1);
      check(32'(code2), 32'(d));
      #2000;
      n = drops;
      drv2({dsfs_pkg::ADDR_CODE, ~d}, 20);
      #400;
      check(32'(drops - n), 32'd1);
      check(32'(code2), 32'(d));
      link2.output_load_n = 1'b1;
      #2000;
      drv2({8'h05, d}, 26);
      $display("test faulty frames done");
      #2000;
      check(32'(drops1), 32'd0);
      check(32'(range2), 32'd0);
      print_verdict();
   end
endmodule : tb_dac_serial_frame_sequencing
